/* pstx_pkg.sv */
// package for the single-wire sensor link: sync qualifier and manchester frame sender
// assumes one 125 MHz clock that stands in for the oscillator
`default_nettype none
package pstx_pkg;
	localparam int CLK_MHZ  = 125;
	localparam int TICK_DIV = 2;
	localparam int TICK_NS  = TICK_DIV * 1000 / CLK_MHZ;
	localparam int START_BITS = 2;
	localparam int WORD_HI    = 10;
	localparam int WORD_LO    = 8;
	localparam int CRC_BITS   = 3;
	localparam int PAR_BITS   = 1;
	localparam int FRAME_MAX  = START_BITS + WORD_HI + CRC_BITS;
	localparam int INTERP_STEPS = 16;
	localparam logic [2:0] CRC_SEED = 3'h7;
	localparam logic [2:0] CRC_POLY = 3'h3;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_QUAL  = 3'h2,
		ST_BLANK = 3'h4
	} pstx_state_type;

	typedef struct packed {
		logic sync_blank_select;
		logic word_length_select;
		logic crc_select;
		logic pulldown_enable;
	} pstx_cfg_type;
endpackage
`default_nettype wire

/* pstx_top.sv */
// sync pulse qualifier, blanking, slot delay, pulldown and manchester-2 frame sender
// assumes comparator, config and sample inputs are synchronous to clk
// Notes on behaviour
// R1 - sample comparator at half rate, count highs
// R2 - after fixed time, count above minimum means valid
// R3 - valid sync pulses flag, starts response scheduling
// R4 - detector reset, disabled for blanking; fixed default
// R5 - variable blanking: slot delay plus frame bits
// R6 - hold sync filter in reset after valid
// R7 - failed candidate resets timers, rearms next sample
// R8 - timers start at first comparator high sample
// R9 - wait slot delay after sync before sending
// R10 - optional pulldown after delay, for set duration
// R11 - zero rises mid-bit, one falls mid-bit
// R12 - mid-bit edge always; idle at quiescent current
// R13 - two start bits, 8/10 data, check bits
// R14 - data word goes out LSB first
// R15 - config picks parity bit or 3-bit CRC
// R16 - parity makes count of ones even
// R17 - CRC polynomial x^3+x+1, seed all ones
// R18 - CRC over data LSB first, three zeros appended
// R19 - CRC table values hold for 10-bit words
// R20 - sent word interpolated 16:1 between two samples
// R21 - both start bits are sent as zero
`default_nettype none
module pstx_top #(
	parameter int TW          = 18,
	parameter int BIT_NS      = 8000,
	parameter int QUAL_NS     = 4000,
	parameter int MIN_SYNC_NS = 2000,
	parameter int BLANK500_NS = 500000,
	parameter int LPF_RST_NS  = 10000,
	parameter int PD_DLY_NS   = 5000,
	parameter int PD_ON_NS    = 10000,
	parameter int SAMPLE_NS   = 16000
) (
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic                  sync_cmp,
	input  wire pstx_pkg::pstx_cfg_type cfg,
	input  wire logic [TW-1:0]         slot_delay,
	input  wire logic                  sample_strobe,
	input  wire logic [9:0]            sample_data,
	output var  logic                  sync_valid,
	output var  logic [TW-1:0]         trigger_time_ref,
	output var  logic                  sync_filter_reset,
	output var  logic                  mod_current,
	output var  logic                  tx_busy
);
	localparam int TK         = pstx_pkg::TICK_NS;
	localparam int QUAL_TICKS = (QUAL_NS + TK - 1) / TK;
	localparam int MIN_TICKS  = (MIN_SYNC_NS + TK - 1) / TK;
	localparam int B500_TICKS = (BLANK500_NS + TK - 1) / TK;
	localparam int LPF_TICKS  = (LPF_RST_NS + TK - 1) / TK;
	localparam int PDD_TICKS  = (PD_DLY_NS + TK - 1) / TK;
	localparam int PDO_TICKS  = (PD_ON_NS + TK - 1) / TK;
	localparam int BIT_TICKS  = BIT_NS / TK;
	localparam int HALF_TICKS = BIT_TICKS / 2;
	localparam int SUB_TICKS  = SAMPLE_NS / TK / pstx_pkg::INTERP_STEPS;
	localparam int FM         = pstx_pkg::FRAME_MAX;

	generate
		if (HALF_TICKS < 1 || SUB_TICKS < 1 || TW < 8 || TW > 30 ||
			B500_TICKS >= (1 << TW) || QUAL_TICKS >= (1 << TW) ||
			QUAL_TICKS + LPF_TICKS >= (1 << TW) || PDD_TICKS + PDO_TICKS >= (1 << TW)) begin : g_chk
			$error("pstx_top: timing parameters do not fit the counters");
		end
	endgenerate

	// reset release through two flops
	logic rst_meta_q, rst_n_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// half-rate sample enable
	logic tick_q;
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) tick_q <= 1'b0;
		else          tick_q <= ~tick_q;
	end
	wire logic tick = tick_q; // R1

	// sync qualifier
	pstx_pkg::pstx_state_type st_q, st_d;
	logic [TW-1:0] trig_q, det_q;
	logic          armed_q;
	wire logic [4:0] nbits_w = 5'(pstx_pkg::START_BITS +
		(cfg.word_length_select ? pstx_pkg::WORD_HI : pstx_pkg::WORD_LO) +
		(cfg.crc_select ? pstx_pkg::CRC_BITS : pstx_pkg::PAR_BITS));
	wire logic [TW-1:0] var_blank_w = slot_delay + TW'(nbits_w * BIT_TICKS); // R5
	wire logic [TW-1:0] blank_len_w = cfg.sync_blank_select ? var_blank_w
		: TW'(B500_TICKS); // R4
	wire logic qual_done_w = (st_q == pstx_pkg::ST_QUAL) && (trig_q == TW'(QUAL_TICKS)); // R2
	wire logic valid_w     = qual_done_w && (det_q > TW'(MIN_TICKS)); // R2
	wire logic start_w     = (st_q == pstx_pkg::ST_IDLE) && sync_cmp; // R8
	wire logic trig_sat_w  = &trig_q;

	always_comb begin
		st_d = st_q;
		case (st_q)
			pstx_pkg::ST_IDLE: begin
				if (start_w) st_d = pstx_pkg::ST_QUAL; // R8
			end
			pstx_pkg::ST_QUAL: begin
				if (qual_done_w) st_d = valid_w ? pstx_pkg::ST_BLANK : pstx_pkg::ST_IDLE; // R7
			end
			pstx_pkg::ST_BLANK: begin
				if (trig_q >= blank_len_w) st_d = pstx_pkg::ST_IDLE; // R4
			end
			default: st_d = pstx_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) st_q <= pstx_pkg::ST_IDLE;
		else if (tick) st_q <= st_d;
	end

	// trigger reference runs from the first high sample so jitter stays at one tick
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) trig_q <= '0;
		else if (tick) begin
			if (st_q == pstx_pkg::ST_IDLE) trig_q <= '0; // R7
			else if (!trig_sat_w) trig_q <= trig_q + TW'(1); // R8
		end
	end

	// detection counter: counts only while qualifying, cleared and idle while blanking
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) det_q <= '0;
		else if (tick) begin
			if (start_w) det_q <= TW'(1); // R1
			else if (st_q == pstx_pkg::ST_QUAL && sync_cmp) det_q <= det_q + TW'(1); // R1
			else if (st_q != pstx_pkg::ST_QUAL) det_q <= '0; // R4
		end
	end

	// interpolation between the two latest samples
	logic [9:0] prev_q, cur_q, word_q;
	logic [3:0] phase_q;
	logic [15:0] sub_q;
	wire logic [9:0] samp_w = cfg.word_length_select ? sample_data
		: {{2{sample_data[7]}}, sample_data[7:0]};
	wire logic signed [10:0] diff_w = $signed({cur_q[9], cur_q}) - $signed({prev_q[9], prev_q});
	// operands widened first so the product of difference and phase cannot wrap
	wire logic signed [15:0] prod_w = 16'(diff_w) * 16'($signed({1'b0, phase_q}));
	wire logic signed [15:0] step_w = prod_w >>> 4;
	wire logic [9:0] interp_w = prev_q + step_w[9:0]; // R20

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			prev_q  <= '0;
			cur_q   <= '0;
			phase_q <= '0;
			sub_q   <= '0;
		end else if (sample_strobe) begin
			prev_q  <= cur_q;
			cur_q   <= samp_w;
			phase_q <= '0;
			sub_q   <= '0;
		end else if (tick) begin
			if (sub_q == 16'(SUB_TICKS - 1)) begin
				sub_q <= '0;
				if (phase_q != 4'hF) phase_q <= phase_q + 4'h1; // R20
			end else begin
				sub_q <= sub_q + 16'h0001;
			end
		end
	end

	// check bits
	function automatic logic [2:0] crc3(input logic [9:0] w, input logic [3:0] n);
		logic [2:0] r;
		logic       b;
		logic       fb;
		r = pstx_pkg::CRC_SEED; // R17
		for (int i = 0; i < 13; i++) begin
			if (i < int'(n) + pstx_pkg::CRC_BITS) begin
				b  = (i < int'(n)) ? w[i] : 1'b0; // R18
				fb = r[2];
				r  = {r[1:0], b} ^ (fb ? pstx_pkg::CRC_POLY : 3'h0); // R17
			end
		end
		return r;
	endfunction

	wire logic [3:0] wlen_w = cfg.word_length_select ? 4'(pstx_pkg::WORD_HI) : 4'(pstx_pkg::WORD_LO);
	wire logic [9:0] wmask_w = cfg.word_length_select ? word_q : {2'h0, word_q[7:0]};
	wire logic [2:0] crc_w = crc3(wmask_w, wlen_w); // R19
	wire logic par_w = ^wmask_w; // R16
	logic [FM-1:0] frame_w;
	always_comb begin
		frame_w = '0; // R21
		frame_w[pstx_pkg::START_BITS +: 10] = wmask_w; // R14
		if (cfg.crc_select) begin // R15
			frame_w[pstx_pkg::START_BITS + int'(wlen_w)]     = crc_w[2];
			frame_w[pstx_pkg::START_BITS + int'(wlen_w) + 1] = crc_w[1];
			frame_w[pstx_pkg::START_BITS + int'(wlen_w) + 2] = crc_w[0];
		end else begin
			frame_w[pstx_pkg::START_BITS + int'(wlen_w)] = par_w; // R16
		end
	end

	// word capture and slot delay arming
	wire logic tx_go_w = tick && armed_q && !tx_busy && (trig_q >= slot_delay); // R9
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			armed_q <= 1'b0;
			word_q  <= '0;
		end else if (tick && valid_w) begin
			armed_q <= 1'b1; // R3
			word_q  <= interp_w; // R20
		end else if (tx_go_w || (tick && st_q == pstx_pkg::ST_IDLE)) begin
			armed_q <= 1'b0;
		end
	end

	// manchester sender
	logic [FM-1:0] sh_q;
	logic [4:0]    left_q;
	logic [15:0]   half_q;
	logic          second_q;
	wire logic half_end_w = tick && tx_busy && (half_q == 16'(HALF_TICKS - 1));
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tx_busy  <= 1'b0;
			sh_q     <= '0;
			left_q   <= '0;
			half_q   <= '0;
			second_q <= 1'b0;
		end else if (tx_go_w) begin
			tx_busy  <= 1'b1; // R13
			sh_q     <= frame_w;
			left_q   <= nbits_w; // R13
			half_q   <= '0;
			second_q <= 1'b0;
		end else if (half_end_w) begin
			half_q   <= '0;
			second_q <= ~second_q; // R12
			if (second_q) begin
				sh_q   <= sh_q >> 1; // R14
				left_q <= left_q - 5'h01;
				if (left_q == 5'h01) tx_busy <= 1'b0;
			end
		end else if (tick && tx_busy) begin
			half_q <= half_q + 16'h0001;
		end
	end

	// high current in the second half means zero, in the first half means one
	wire logic tx_level_w = tx_busy && (second_q ? ~sh_q[0] : sh_q[0]); // R11
	wire logic pd_on_w = cfg.pulldown_enable && (st_q == pstx_pkg::ST_BLANK) &&
		(trig_q >= TW'(PDD_TICKS)) && (trig_q < TW'(PDD_TICKS + PDO_TICKS)); // R10
	wire logic lpf_d_w = (st_q == pstx_pkg::ST_BLANK) &&
		(trig_q < TW'(QUAL_TICKS + LPF_TICKS)); // R6

	// outputs straight from flops; sync flag is one clk wide
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sync_valid        <= 1'b0;
			trigger_time_ref  <= '0;
			sync_filter_reset <= 1'b0;
			mod_current       <= 1'b0;
		end else begin
			sync_valid        <= tick && valid_w; // R3
			trigger_time_ref  <= trig_q; // R3
			sync_filter_reset <= lpf_d_w || (tick && valid_w); // R6
			mod_current       <= (tx_level_w && tx_busy) || pd_on_w; // R12
		end
	end
endmodule // pstx_top
`default_nettype wire

/* pstx_checker.sv */
// port assertions for the sync qualifier and frame sender
// assumes binding into pstx_top; the mid-bit check holds for 32-clock bits only
`default_nettype none
module pstx_checker #(
	parameter int TW      = 18,
	parameter int BIT_NS  = 8000,
	parameter int QUAL_NS = 4000
) (
	input wire logic                   clk,
	input wire logic                   rstn,
	input wire pstx_pkg::pstx_cfg_type cfg,
	input wire logic [TW-1:0]          slot_delay,
	input wire logic                   sync_valid,
	input wire logic [TW-1:0]          trigger_time_ref,
	input wire logic                   sync_filter_reset,
	input wire logic                   mod_current,
	input wire logic                   tx_busy
);
	localparam int BCLK = 2 * (BIT_NS / pstx_pkg::TICK_NS);
	localparam int QT   = (QUAL_NS + pstx_pkg::TICK_NS - 1) / pstx_pkg::TICK_NS;
	logic [15:0] len_q;
	logic [7:0]  ph_q;
	logic [4:0]  nbits;
	assign nbits = 5'(2 + (cfg.word_length_select ? 10 : 8) + (cfg.crc_select ? 3 : 1));
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) {len_q, ph_q} <= 24'h0;
		else {len_q, ph_q} <= tx_busy ? {len_q + 16'h1, ph_q == 8'(BCLK - 1) ? 8'h0 : ph_q + 8'h1} : 24'h0;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_frame_end; $fell(tx_busy); endsequence
	sequence s_first_half; tx_busy && ph_q == 8'h4; endsequence
	a_valid_one_pulse: assert property (sync_valid |=> !sync_valid)
		else $error("valid too long");
	a_filter_after_valid: assert property (sync_valid |-> ##[0:2] sync_filter_reset)
		else $error("filter not held");
	a_valid_at_qual: assert property (sync_valid |-> trigger_time_ref inside {[QT-1:QT+1]})
		else $error("valid off time");
	a_slot_wait: assert property ($rose(tx_busy) |-> trigger_time_ref + 1 >= slot_delay)
		else $error("frame early");
	a_idle_quiet: assert property (!cfg.pulldown_enable && !tx_busy && !$past(tx_busy) |-> !mod_current)
		else $error("idle current");
	a_frame_length: assert property (s_frame_end |-> len_q == 16'(nbits * BCLK))
		else $error("frame length");
	a_mid_bit_edge: assert property (s_first_half |-> ##16 mod_current != $past(mod_current, 16))
		else $error("no mid-bit edge");
	a_blank_no_valid: assert property (tx_busy |-> !sync_valid)
		else $error("sync in frame");
endmodule // pstx_checker
bind pstx_top pstx_checker #(.BIT_NS(BIT_NS), .QUAL_NS(QUAL_NS)) i_pstx_checker (
	.clk(clk), .rstn(rstn), .cfg(cfg), .slot_delay(slot_delay), .sync_valid(sync_valid),
	.trigger_time_ref(trigger_time_ref), .sync_filter_reset(sync_filter_reset),
	.mod_current(mod_current), .tx_busy(tx_busy));
`default_nettype wire

/* pstx_master.sv */
// link master model: raises the supply for sync, decodes the returned current
// assumes the shared clk and 32-clock bits
`default_nettype none
module pstx_master (
	input  wire logic clk,
	input  wire logic tx_busy,
	input  wire logic mod_current,
	input  wire logic sync_valid,
	input  wire logic sync_filter_reset,
	output var  logic sync_cmp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [14:0] bits;
	logic        busy_p = 1'b0;
	int          nb, bad, nvalid, npd, nlpf, cyc, t0, trise;
	initial sync_cmp = 1'b0;
	always @(negedge clk) begin
		cyc++;
		nvalid += sync_valid;
		nlpf += sync_filter_reset;
		npd += !tx_busy && !busy_p && mod_current;
		busy_p = tx_busy;
	end
	task automatic pulse(input int clks);
		@(posedge clk);
		sync_cmp <= 1'b1;
		t0 = cyc;
		repeat (clks) @(posedge clk);
		sync_cmp <= 1'b0;
	endtask
	// mid-half sampling tolerates one clock of output lag
	always @(posedge tx_busy) begin
		trise = cyc;
		nb = 0;
		bits = 15'h0;
		repeat (8) @(negedge clk);
		while (tx_busy) begin
			bits[nb] = mod_current;
			repeat (16) @(negedge clk);
			bad += bits[nb] == mod_current;
			nb++;
			repeat (16) @(negedge clk);
		end
	end
endmodule // pstx_master
`default_nettype wire

/* tb.sv */
// bench for the link block: qualification, blanking, pulldown, frame content
// assumes scaled timing of 16 ticks a bit
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                   clk, rstn, sync_cmp, sample_strobe;
	logic                   sync_valid, sync_filter_reset, mod_current, tx_busy;
	pstx_pkg::pstx_cfg_type cfg;
	logic [17:0]            slot_delay;
	logic [9:0]             sample_data;
	int                     errors, n_compared;
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
	$display("ERROR %0t: got %0h expected %0h", $time, got, exp); end end
	pstx_top #(.BIT_NS(256), .QUAL_NS(160), .MIN_SYNC_NS(80), .BLANK500_NS(20000),
		.LPF_RST_NS(160), .PD_DLY_NS(160), .PD_ON_NS(160)) i_pstx_top (
		.clk(clk), .rstn(rstn), .sync_cmp(sync_cmp), .cfg(cfg), .slot_delay(slot_delay),
		.sample_strobe(sample_strobe), .sample_data(sample_data), .sync_valid(sync_valid),
		.trigger_time_ref(), .sync_filter_reset(sync_filter_reset),
		.mod_current(mod_current), .tx_busy(tx_busy));
	pstx_master i_pstx_master (.clk(clk), .tx_busy(tx_busy), .mod_current(mod_current),
		.sync_valid(sync_valid), .sync_filter_reset(sync_filter_reset), .sync_cmp(sync_cmp));
	function automatic logic [2:0] crc3(input logic [9:0] d, input int n);
		logic [2:0] r;
		r = 3'h7;
		for (int i = 0; i < n + 3; i++)
			r = {r[1:0], (i < n) ? d[i] : 1'b0} ^ (r[2] ? 3'h3 : 3'h0);
		return r;
	endfunction
	task automatic frame(input logic [3:0] c, input int slot, input logic [9:0] d);
		int n, st, k;
		logic [14:0] e;
		logic [2:0] r;
		n = c[2] ? 10 : 8;
		st = slot > 10 ? slot : 10;
		r = crc3(d, n);
		e = 15'(d & (c[2] ? 10'h3FF : 10'h0FF)) << 2;
		if (c[1]) e = e | (15'({r[0], r[1], r[2]}) << (n + 2));
		else e[n + 2] = ^e;
		cfg <= pstx_pkg::pstx_cfg_type'(c);
		slot_delay <= 18'(slot);
		sample_data <= d;
		repeat (2) begin
			repeat (128) @(posedge clk);
			sample_strobe <= 1'b1;
			@(posedge clk);
			sample_strobe <= 1'b0;
		end
		i_pstx_master.nvalid = 0;
		i_pstx_master.npd = 0;
		i_pstx_master.nlpf = 0;
		i_pstx_master.pulse(12);
		k = 0;
		while ((!tx_busy || k < 40) && k < 3000) begin
			@(posedge clk);
			k = tx_busy ? 40 : k + 1;
		end
		while (tx_busy && k < 3000) begin
			@(posedge clk);
			k++;
		end
		repeat (40) @(posedge clk);
		`CHK(i_pstx_master.nb, n + (c[1] ? 5 : 3))
		`CHK(i_pstx_master.bits, e)
		`CHK(i_pstx_master.bad, 0)
		`CHK(i_pstx_master.trise - i_pstx_master.t0 inside {[2 * st : 2 * st + 6]}, 1'b1)
		`CHK(i_pstx_master.nlpf inside {[17:21]}, 1'b1)
		`CHK(i_pstx_master.npd inside {[17:21]}, c[0])
		i_pstx_master.pulse(12);
		repeat (2700) @(posedge clk);
		`CHK(i_pstx_master.nvalid, 1 + c[3])
	endtask
	task automatic conclude;
		if (errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		conclude;
	end
	initial begin
		rstn = 1'b0;
		cfg = '0;
		slot_delay = 18'h0;
		sample_strobe = 1'b0;
		sample_data = 10'h0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		i_pstx_master.pulse(10);
		repeat (40) @(posedge clk);
		`CHK(i_pstx_master.nvalid, 0)
		frame(4'h6, 20, 10'h000);
		frame(4'hE, 5, 10'h3FF);
		frame(4'h6, 300, 10'h0CC);
		frame(4'hD, 300, 10'h151);
		frame(4'h1, 40, 10'h0A5);
		frame(4'hA, 0, 10'h081);
		conclude;
	end
endmodule // tb
`default_nettype wire
